/* File: rtl/pwm_unit.sv */
// Register access over APB and the placing of the registers were chosen for this implementation.
`default_nettype none
// Contract
// R1: Pin carries ten-bit resolution modulated output.
// R2: Software clears direction bit to drive pin.
// R3: Zero unit control forces output latch low.
// R4: Period is (limit+1)*4*oscillator*prescale.
// R5: After limit match: clear counter, set pin, load.
// R6: Zero duty keeps pin low at period start.
// R7: Duty is high byte plus two control bits.
// R8: High time is duty*oscillator*prescale.
// R9: Duty writes apply only at period end.
// R10: Shadow register read-only in modulation mode.
// R11: Shadow plus two-bit latch double-buffer duty.
// R12: Pin clears when buffered duty equals count.
// R13: Duty beyond period keeps pin high.
// R14: Software follows the advised setup order.
// R15: Prescaler divides by one, four, sixteen.
// R16: Select 00 one, 01 four, 1x sixteen.
module pwm_unit
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pwm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pwm_pkg::DATA_W-1:0] pwdata,
    output logic      [pwm_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            modulator_pin_out,
    output logic                            modulator_pin_oe_n
);
    import pwm_pkg::*;

    logic [7:0] base_counter;
    logic [7:0] period_limit;
    logic [7:0] base_timer_control;
    logic [7:0] duty_high_byte;
    logic [7:0] duty_shadow;
    logic [7:0] unit_control;
    logic [7:0] port_direction;
    logic [7:0] port_data;
    logic [1:0] duty_latch;
    logic [1:0] quarter;
    logic [3:0] prescaler;
    logic       pwm_latch;

    logic       addr_hit;
    logic       wr_access;
    logic       setup_read;
    logic [7:0] read_byte;
    logic       pwm_mode;
    logic       timer_on;
    logic [3:0] presc_mask;
    logic       cycle_tick;
    logic       timer_inc;
    logic       period_end;
    logic [1:0] count_low;
    logic [9:0] next_duty;
    logic       duty_match;

    // APB decode
    always_comb
    begin
        addr_hit  = 1'b1;
        read_byte = 8'h00;
        if (paddr == ADDR_BASE_COUNTER)
        begin
            read_byte = base_counter;
        end
        else if (paddr == ADDR_PERIOD_LIMIT)
        begin
            read_byte = period_limit;
        end
        else if (paddr == ADDR_TIMER_CONTROL)
        begin
            read_byte = base_timer_control;
        end
        else if (paddr == ADDR_DUTY_HIGH)
        begin
            read_byte = duty_high_byte;
        end
        else if (paddr == ADDR_DUTY_SHADOW)
        begin
            read_byte = duty_shadow;
        end
        else if (paddr == ADDR_UNIT_CONTROL)
        begin
            read_byte = unit_control;
        end
        else if (paddr == ADDR_PORT_DIRECTION)
        begin
            read_byte = port_direction;
        end
        else if (paddr == ADDR_PORT_DATA)
        begin
            read_byte = port_data;
        end
        else
        begin
            addr_hit = 1'b0;
        end
    end

    // Zero wait states; the read word is captured in the setup cycle
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~addr_hit;
    assign wr_access  = psel & penable & pwrite & addr_hit;
    assign setup_read = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (setup_read)
        begin
            prdata <= {24'h000000, read_byte};
        end
    end

    assign pwm_mode = unit_control[POS_MODE_HI:POS_MODE_LO] == MODE_PWM;
    assign timer_on = base_timer_control[POS_TIMER_ON];

    always_comb
    begin
        if (base_timer_control[POS_PRESCALE_HI])
        begin
            presc_mask = PRESC_MASK_DIV16; // [R16]
            count_low  = prescaler[3:2];
        end
        else if (base_timer_control[POS_PRESCALE_LO])
        begin
            presc_mask = PRESC_MASK_DIV4; // [R16]
            count_low  = prescaler[1:0];
        end
        else
        begin
            presc_mask = PRESC_MASK_DIV1; // [R16]
            count_low  = quarter;
        end
    end

    // Four oscillator periods per timer input cycle
    assign cycle_tick = quarter == QUARTER_LAST; // [R4]
    assign timer_inc  = timer_on & cycle_tick & ((prescaler & presc_mask) == presc_mask); // [R15]
    assign period_end = timer_inc & (base_counter == period_limit); // [R4]
    assign next_duty  = {duty_high_byte, unit_control[POS_DUTY_LOW_HI:POS_DUTY_LOW_LO]}; // [R7]
    // Match the count about to appear, so the pin falls as that count starts, not one later
    assign duty_match = timer_on & (({prescaler[1:0], quarter} & presc_mask) == presc_mask) &
        ({duty_shadow, duty_latch} == {base_counter, count_low} + 10'h001); // [R8] [R12]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quarter <= RST_QUARTER;
        end
        else
        begin
            quarter <= quarter + 2'h1;
        end
    end

    // Prescale count, cleared while the timer is off or the counter is written; bits 1:0 or 3:2 double as the extended compare bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescaler <= RST_PRESCALER;
        end
        else if (!timer_on || (wr_access && paddr == ADDR_BASE_COUNTER))
        begin
            prescaler <= RST_PRESCALER;
        end
        else if (cycle_tick)
        begin
            prescaler <= prescaler + 4'h1; // [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base_counter <= RST_BASE_COUNTER;
        end
        else if (wr_access && paddr == ADDR_BASE_COUNTER)
        begin
            base_counter <= pwdata[7:0];
        end
        else if (period_end)
        begin
            base_counter <= RST_BASE_COUNTER; // [R5]
        end
        else if (timer_inc)
        begin
            base_counter <= base_counter + 8'h01;
        end
    end

    // Configuration registers; duty bytes may be written at any moment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period_limit       <= RST_PERIOD_LIMIT;
            base_timer_control <= RST_TIMER_CONTROL;
            duty_high_byte     <= RST_DUTY_HIGH;
            unit_control       <= RST_UNIT_CONTROL;
            port_direction     <= RST_PORT_DIRECTION;
            port_data          <= RST_PORT_DATA;
        end
        else if (wr_access)
        begin
            if (paddr == ADDR_PERIOD_LIMIT)
            begin
                period_limit <= pwdata[7:0];
            end
            else if (paddr == ADDR_TIMER_CONTROL)
            begin
                base_timer_control <= pwdata[7:0] & MASK_TIMER_CONTROL;
            end
            else if (paddr == ADDR_DUTY_HIGH)
            begin
                duty_high_byte <= pwdata[7:0]; // [R9]
            end
            else if (paddr == ADDR_UNIT_CONTROL)
            begin
                unit_control <= pwdata[7:0] & MASK_UNIT_CONTROL; // [R9]
            end
            else if (paddr == ADDR_PORT_DIRECTION)
            begin
                port_direction <= pwdata[7:0];
            end
            else if (paddr == ADDR_PORT_DATA)
            begin
                port_data <= pwdata[7:0];
            end
        end
    end

    // Shadow and two-bit latch change only at period end in modulation mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_shadow <= RST_DUTY_SHADOW;
            duty_latch  <= RST_DUTY_LATCH;
        end
        else if (period_end)
        begin
            duty_shadow <= next_duty[9:2]; // [R5] [R11]
            duty_latch  <= next_duty[1:0]; // [R11]
        end
        else if (wr_access && paddr == ADDR_DUTY_SHADOW && !pwm_mode)
        begin
            duty_shadow <= pwdata[7:0]; // [R10]
        end
    end

    // Period start wins over the compare clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_latch <= 1'b0;
        end
        else if (!pwm_mode)
        begin
            pwm_latch <= 1'b0; // [R3]
        end
        else if (wr_access && paddr == ADDR_UNIT_CONTROL && pwdata[7:0] == 8'h00)
        begin
            pwm_latch <= 1'b0; // [R3]
        end
        else if (period_end)
        begin
            pwm_latch <= next_duty != 10'h000; // [R5] [R6]
        end
        else if (duty_match)
        begin
            pwm_latch <= 1'b0; // [R12] [R13]
        end
    end

    // Pin shares the port latch; only the mode selects which one drives it
    assign modulator_pin_out  = pwm_mode ? pwm_latch : port_data[POS_PIN]; // [R1] [R3]
    assign modulator_pin_oe_n = port_direction[POS_PIN]; // [R2]

    property p_counter_clear;
        @(posedge pclk) disable iff (!presetn)
        period_end && !(wr_access && paddr == ADDR_BASE_COUNTER) |=> base_counter == 8'h00;
    endproperty
    a_counter_clear: assert property (p_counter_clear) // [R5] [R4]
        else $error("counter not cleared after limit match");

    property p_shadow_load;
        @(posedge pclk) disable iff (!presetn)
        period_end |=> {duty_shadow, duty_latch} ==
            {$past(duty_high_byte), $past(unit_control[5:4])};
    endproperty
    a_shadow_load: assert property (p_shadow_load) // [R11]
        else $error("duty not loaded into shadow at period end");

    property p_pin_set;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && period_end && next_duty != 10'h000 && !wr_access |=> pwm_latch;
    endproperty
    a_pin_set: assert property (p_pin_set) // [R5]
        else $error("pin not set at period start");

    property p_zero_duty;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && period_end && next_duty == 10'h000 |=> !modulator_pin_out;
    endproperty
    a_zero_duty: assert property (p_zero_duty) // [R6]
        else $error("pin set with zero duty");

    property p_control_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_access && paddr == ADDR_UNIT_CONTROL && pwdata[7:0] == 8'h00 |=> !pwm_latch;
    endproperty
    a_control_clear: assert property (p_control_clear) // [R3]
        else $error("output latch not forced low");

    property p_shadow_locked;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && !period_end |=> $stable(duty_shadow);
    endproperty
    a_shadow_locked: assert property (p_shadow_locked) // [R9] [R10]
        else $error("shadow changed outside period end");

    property p_compare_clear;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && duty_match && !period_end |=> !pwm_latch;
    endproperty
    a_compare_clear: assert property (p_compare_clear) // [R12]
        else $error("pin not cleared on duty match");

    property p_div16;
        @(posedge pclk) disable iff (!presetn)
        timer_inc && base_timer_control[1] |-> prescaler == 4'hf && quarter == 2'h3;
    endproperty
    a_div16: assert property (p_div16) // [R15] [R16]
        else $error("divide by sixteen tick misplaced");

    property p_div1_spacing;
        @(posedge pclk) disable iff (!presetn)
        timer_inc && base_timer_control[1:0] == 2'b00 && !$changed(base_timer_control)
            |=> !timer_inc [*3];
    endproperty
    a_div1_spacing: assert property (p_div1_spacing) // [R4]
        else $error("timer increments faster than every four clocks");

    property p_pin_follows;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode |-> modulator_pin_out == pwm_latch;
    endproperty
    a_pin_follows: assert property (p_pin_follows) // [R1]
        else $error("pin does not follow modulation latch");

    c_period: cover property (@(posedge pclk) disable iff (!presetn) pwm_mode && period_end);
    c_match: cover property (@(posedge pclk) disable iff (!presetn)
        pwm_mode && duty_match && pwm_latch);
    c_div16: cover property (@(posedge pclk) disable iff (!presetn)
        timer_inc && base_timer_control[1]);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

/* File: rtl/pwm_pkg.sv */
`default_nettype none
package pwm_pkg;
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0]  ADDR_BASE_COUNTER   = 8'h00;
    localparam logic [7:0]  ADDR_PERIOD_LIMIT   = 8'h04;
    localparam logic [7:0]  ADDR_TIMER_CONTROL  = 8'h08;
    localparam logic [7:0]  ADDR_DUTY_HIGH      = 8'h0c;
    localparam logic [7:0]  ADDR_DUTY_SHADOW    = 8'h10;
    localparam logic [7:0]  ADDR_UNIT_CONTROL   = 8'h14;
    localparam logic [7:0]  ADDR_PORT_DIRECTION = 8'h18;
    localparam logic [7:0]  ADDR_PORT_DATA      = 8'h1c;

    // Values after reset
    localparam logic [7:0]  RST_BASE_COUNTER    = 8'h00;
    localparam logic [7:0]  RST_PERIOD_LIMIT    = 8'hff;
    localparam logic [7:0]  RST_TIMER_CONTROL   = 8'h00;
    localparam logic [7:0]  RST_DUTY_HIGH       = 8'h00;
    localparam logic [7:0]  RST_DUTY_SHADOW     = 8'h00;
    localparam logic [7:0]  RST_UNIT_CONTROL    = 8'h00;
    localparam logic [7:0]  RST_PORT_DIRECTION  = 8'hff;
    localparam logic [7:0]  RST_PORT_DATA       = 8'h00;
    localparam logic [1:0]  RST_DUTY_LATCH      = 2'h0;
    localparam logic [1:0]  RST_QUARTER         = 2'h0;
    localparam logic [3:0]  RST_PRESCALER       = 4'h0;

    // Writable bits of the partly implemented registers
    localparam logic [7:0]  MASK_TIMER_CONTROL  = 8'h7f;
    localparam logic [7:0]  MASK_UNIT_CONTROL   = 8'h3f;

    // Field positions
    localparam int          POS_TIMER_ON        = 2;
    localparam int          POS_PRESCALE_HI     = 1;
    localparam int          POS_PRESCALE_LO     = 0;
    localparam int          POS_DUTY_LOW_HI     = 5;
    localparam int          POS_DUTY_LOW_LO     = 4;
    localparam int          POS_MODE_HI         = 3;
    localparam int          POS_MODE_LO         = 2;
    localparam int          POS_PIN             = 2;

    // Mode bits 3:2 both set select modulation
    localparam logic [1:0]  MODE_PWM            = 2'h3;

    // Oscillator periods per timer input cycle, last quarter index
    localparam logic [1:0]  QUARTER_LAST        = 2'h3;

    // Prescaler terminal masks: divide by one, four, sixteen
    localparam logic [3:0]  PRESC_MASK_DIV1     = 4'h0;
    localparam logic [3:0]  PRESC_MASK_DIV4     = 4'h3;
    localparam logic [3:0]  PRESC_MASK_DIV16    = 4'hf;
endpackage
`default_nettype wire

/* File: testbench/pwm_load.sv */
`default_nettype none
module pwm_load
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin_out,
    input  wire logic        pin_oe_n,
    output logic      [15:0] high_cycles,
    output logic      [15:0] period_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        level;
    logic        prev;
    logic [15:0] high_run;
    logic [15:0] period_run;
    // Pull-down holds the line low while the pin is not driven
    assign level = pin_oe_n ? 1'b0 : pin_out;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= 1'b0;
            high_run <= 16'h0;
            period_run <= 16'h0;
            high_cycles <= 16'h0;
            period_cycles <= 16'h0;
        end
        else
        begin
            prev <= level;
            period_run <= (level && !prev) ? 16'h1 : period_run + 16'h1;
            high_run <= level ? high_run + 16'h1 : 16'h0;
            if (level && !prev)
                period_cycles <= period_run;
            if (!level && prev)
                high_cycles <= high_run;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_out;
    logic        pin_oe_n;
    logic [15:0] high_cycles;
    logic [15:0] period_cycles;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          compares;
    logic [7:0]  addrs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [7:0]  rstv [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [15:0] fac [4] = '{16'd1, 16'd4, 16'd16, 16'd16};

    pwm_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modulator_pin_out(pin_out), .modulator_pin_oe_n(pin_oe_n));
    pwm_load i_load (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .high_cycles(high_cycles), .period_cycles(period_cycles));

    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Period start is the only safe moment to touch duty with a known shadow
    task automatic wait_rise;
        int n;
        n = 0;
        while (pin_out !== 1'b0 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        while (pin_out !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000)
        begin
            fails++;
            close_out();
        end
    endtask

    task automatic hold_chk(input logic v);
        int bad;
        bad = 0;
        repeat (40)
        begin
            @(posedge pclk);
            if (pin_out !== v)
                bad++;
        end
        `CHK(bad, 0)
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fails = 0;
        compares = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (addrs[i])
        begin
            apb(1'b0, addrs[i], 32'h0);
            `CHK(rd, {24'h0, rstv[i]})
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        `CHK(pin_oe_n, 1'b1)
        apb(1'b1, ADDR_PERIOD_LIMIT, 32'h3);
        apb(1'b1, ADDR_DUTY_HIGH, 32'h2);
        apb(1'b1, ADDR_UNIT_CONTROL, 32'h10);
        apb(1'b1, ADDR_PORT_DIRECTION, 32'hfb);
        apb(1'b1, ADDR_TIMER_CONTROL, 32'h4);
        `CHK(pin_oe_n, 1'b0)
        apb(1'b1, ADDR_UNIT_CONTROL, 32'h1c);
        // Duty 9 against a 16-cycle base period, scaled by each prescale
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, ADDR_TIMER_CONTROL, 32'h4 | s);
            repeat (800) @(posedge pclk);
            `CHK(period_cycles, 16'd16 * fac[s])
            `CHK(high_cycles, 16'd9 * fac[s])
        end
        apb(1'b1, ADDR_TIMER_CONTROL, 32'h4);
        wait_rise();
        apb(1'b1, ADDR_DUTY_HIGH, 32'h1);
        apb(1'b1, ADDR_DUTY_SHADOW, 32'h55);
        apb(1'b0, ADDR_DUTY_SHADOW, 32'h0);
        `CHK(rd[7:0], 8'h02)
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_DUTY_SHADOW, 32'h0);
        `CHK(rd[7:0], 8'h01)
        `CHK(high_cycles, 16'd5)
        apb(1'b0, ADDR_BASE_COUNTER, 32'h0);
        `CHK(rd[7:0] <= 8'h3, 1'b1)
        apb(1'b1, ADDR_DUTY_HIGH, 32'h0);
        apb(1'b1, ADDR_UNIT_CONTROL, 32'h0c);
        repeat (40) @(posedge pclk);
        hold_chk(1'b0);
        apb(1'b1, ADDR_DUTY_HIGH, 32'hff);
        repeat (40) @(posedge pclk);
        hold_chk(1'b1);
        apb(1'b1, ADDR_PORT_DATA, 32'h4);
        // Restart the count so the next period start is known to be far off
        apb(1'b1, ADDR_BASE_COUNTER, 32'h0);
        apb(1'b1, ADDR_UNIT_CONTROL, 32'h0);
        apb(1'b0, ADDR_PORT_DATA, 32'h0);
        `CHK({pin_out, rd[7:0]}, {1'b1, 8'h04})
        apb(1'b1, ADDR_UNIT_CONTROL, 32'h0c);
        apb(1'b0, ADDR_UNIT_CONTROL, 32'h0);
        `CHK(pin_out, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
